/* File: cds_pkg.sv */
// Shared constants for the channel diagnosis and status block
package cds_pkg;

    // Number of power channels served by the diagnosis logic
    localparam int CDS_NUM_CH = 6;

    // Width of the sense channel select field
    localparam int CDS_SEL_W = 3;

    // Select code that disables the sense output
    localparam logic [2:0] CDS_SENSE_OFF_SEL = 3'h6;

    // Width of the in-frame serial clock edge counter
    localparam int CDS_EDGE_W = 2;

    // Counter value just before the edge that starts the clear window
    localparam logic [1:0] CDS_CLR_EDGE_PRE = 2'h1;

    // Counter value just before the edge that sets the re-arm point
    localparam logic [1:0] CDS_ARM_EDGE_PRE = 2'h2;

    // Counter saturation value
    localparam logic [1:0] CDS_EDGE_MAX = 2'h3;

    // Reset value of all per-channel flag vectors
    localparam logic [5:0] CDS_FLAGS_RST = 6'h00;

    // Reset value of the sense select copy
    localparam logic [2:0] CDS_SEL_RST = 3'h6;

    // Reset value of two-flop synchroniser stages
    localparam logic [1:0] CDS_SYNC_RST = 2'h0;

    // States of the thermal copy re-arm sequence
    typedef enum logic [1:0] {
        CDS_OT_ARMED,
        CDS_OT_WAIT_FRAME,
        CDS_OT_WAIT_ARM
    } cds_ot_state_t;

endpackage

/* File: cds_sync.sv */
// Two-flop level synchroniser into the system clock domain
`timescale 1ns/1ps
module cds_sync #(
    parameter int WIDTH = 1
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    // First stage is read by the second stage only
    logic [WIDTH-1:0] meta_reg;

    // Two flops in a row, cleared by the synchronous reset
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule

/* File: cds_link.sv */
// Serial clock side: counts rising edges within each frame
`timescale 1ns/1ps
module cds_link (
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_diag_frame,
    output logic clr_window_reg,
    output logic arm_point_reg,
    output logic diag_clear_reg,
    output logic frame_active_reg
);

    // Rising edges seen in the current frame, saturating
    logic [cds_pkg::CDS_EDGE_W-1:0] edge_cnt_reg;

    // The serial clock stands still between frames, so everything here is
    // cleared by the frame select itself rather than by a clock edge
    always_ff @(posedge spi_sclk or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            edge_cnt_reg <= '0;
        end else if (edge_cnt_reg != cds_pkg::CDS_EDGE_MAX) begin
            edge_cnt_reg <= edge_cnt_reg + 2'h1;
        end
    end

    // Frame running: set on first edge, so a bare select glitch is ignored
    always_ff @(posedge spi_sclk or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            frame_active_reg <= 1'b0;
        end else begin
            frame_active_reg <= 1'b1;
        end
    end

    // Clear window opens at the second rising edge
    always_ff @(posedge spi_sclk or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            clr_window_reg <= 1'b0;
        end else if (edge_cnt_reg == cds_pkg::CDS_CLR_EDGE_PRE) begin
            clr_window_reg <= 1'b1; // R3
        end
    end

    // Diagnosis-word clear only when the frame carries that word
    always_ff @(posedge spi_sclk or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            diag_clear_reg <= 1'b0;
        end else if (edge_cnt_reg == cds_pkg::CDS_CLR_EDGE_PRE) begin
            diag_clear_reg <= spi_diag_frame; // R2
        end
    end

    // Re-arm point is the third rising edge
    always_ff @(posedge spi_sclk or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            arm_point_reg <= 1'b0;
        end else if (edge_cnt_reg == cds_pkg::CDS_ARM_EDGE_PRE) begin
            arm_point_reg <= 1'b1; // R5
        end
    end

endmodule

/* File: cds_diag.sv */
// Per-channel fault flags, sense routing and bypass monitor result
//
// What this block does
// R1: Fault bit is thermal copy OR overload.
// R2: Overload flag sticks until diagnosis word sent.
// R3: Overload clear between second and third edge.
// R4: Thermal latch keeps channel off until cleared.
// R5: Thermal copy cleared next frame, re-armed edge three.
// R6: First word after clear still shows thermal fault.
// R7: Persistent overload sets flag again after clear.
// R8: Thermal latch held even when channel off.
// R9: On-state faults read one, others zero.
// R10: Sense driven only when on and fault-free.
// R11: Overcurrent or overheat switches sense off.
// R12: Select field routes one channel or none.
// R13: Bypass bit compares selected channel threshold.
// R14: Bypass bit one near ground, zero near supply.
// R15: Clear command bit one clears all latches; a sensor still hot keeps its latch set.
// R16: Dynamic shutdown sets flag again after read.
// R17: Select code 110 disables sense output.
// R18: Word snapshot taken before in-frame clear.
`timescale 1ns/1ps
module cds_diag (
    input wire logic sys_clk,
    input wire logic rst,
    // Serial link, its own clock domain
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_diag_frame,
    // Hardware configuration command write, system domain
    input wire logic hardware_config_command_wr,
    input wire logic clear_thermal_latch,
    // Sense channel select field, system domain
    input wire logic [2:0] sense_channel_select,
    // Channel on commands, system domain
    input wire logic [5:0] channel_on_command,
    // Analog monitor pins, asynchronous
    input wire logic [5:0] overload_in,
    input wire logic [5:0] dyn_temp_shutdown_in,
    input wire logic [5:0] over_temp_in,
    input wire logic [5:0] out_near_gnd_in,
    // Results
    output logic [5:0] channel_fault_flag,
    output logic [5:0] diag_word_snapshot,
    output logic [5:0] gate_enable,
    output logic [5:0] thermal_latch,
    output logic sense_drive_en,
    output logic [2:0] sense_route,
    output logic bypass_monitor_result
);

    // True when the select code names a real channel
    function automatic logic sel_is_channel(input logic [2:0] sel);
        sel_is_channel = (sel < cds_pkg::CDS_SENSE_OFF_SEL) &&
            (sel < 3'(cds_pkg::CDS_NUM_CH));
    endfunction

    // One-hot channel mask for a select code, zero when disabled
    function automatic logic [5:0] sel_mask(input logic [2:0] sel);
        sel_mask = sel_is_channel(sel) ? (6'h01 << sel) : 6'h00;
    endfunction

    // Link-domain markers
    logic clr_window_lnk;
    logic arm_point_lnk;
    logic diag_clear_lnk;
    logic frame_active_lnk;

    // Synchronised copies of the link markers
    logic [3:0] lnk_sync;
    logic [3:0] lnk_prev_reg;

    // Synchronised analog monitor inputs
    logic [5:0] overload_s;
    logic [5:0] dyn_sd_s;
    logic [5:0] over_temp_s;
    logic [5:0] near_gnd_s;

    // Event pulses decoded from the link markers
    logic frame_start;
    logic clr_point;
    logic diag_clr_point;
    logic arm_point;

    // Sticky overload part of the fault flag
    logic [5:0] overload_flag_reg;

    // Thermal latch at gate control
    logic [5:0] ot_latch_reg;

    // Second thermal copy held in the fault flag
    logic [5:0] ot_copy_reg;

    // Re-arm sequence state for the thermal copy
    cds_pkg::cds_ot_state_t ot_state_reg;
    cds_pkg::cds_ot_state_t ot_state_next;

    // Clear command accepted this cycle
    logic ctl_cmd;

    // Frame-level edge counting runs on the serial clock
    cds_link u_link (
        .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n),
        .spi_diag_frame(spi_diag_frame),
        .clr_window_reg(clr_window_lnk),
        .arm_point_reg(arm_point_lnk),
        .diag_clear_reg(diag_clear_lnk),
        .frame_active_reg(frame_active_lnk)
    );

    // Markers are levels held to frame end, so a plain two-flop sync fits
    cds_sync #(.WIDTH(4)) u_sync_lnk (
        .sys_clk(sys_clk),
        .rst(rst),
        .async_in({frame_active_lnk, arm_point_lnk, diag_clear_lnk,
            clr_window_lnk}),
        .sync_out(lnk_sync)
    );

    // Analog monitor pins are bundled through one synchroniser
    cds_sync #(.WIDTH(24)) u_sync_pins (
        .sys_clk(sys_clk),
        .rst(rst),
        .async_in({out_near_gnd_in, over_temp_in, dyn_temp_shutdown_in,
            overload_in}),
        .sync_out({near_gnd_s, over_temp_s, dyn_sd_s, overload_s})
    );

    // Previous marker values for rising-edge detection
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            lnk_prev_reg <= 4'h0;
        end else begin
            lnk_prev_reg <= lnk_sync;
        end
    end

    // Rising edges of the synchronised markers
    assign clr_point = lnk_sync[0] & ~lnk_prev_reg[0];
    assign diag_clr_point = lnk_sync[1] & ~lnk_prev_reg[1];
    assign arm_point = lnk_sync[2] & ~lnk_prev_reg[2];
    assign frame_start = lnk_sync[3] & ~lnk_prev_reg[3];

    // Clear command only on a write with the bit set
    assign ctl_cmd = hardware_config_command_wr & clear_thermal_latch; // R15

    // Snapshot of the word taken at frame start, ahead of the clear point
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            diag_word_snapshot <= cds_pkg::CDS_FLAGS_RST;
        end else if (frame_start) begin
            // Includes overload and dynamic shutdown events landing in this very cycle
            diag_word_snapshot <= overload_flag_reg | ot_copy_reg |
                overload_s | dyn_sd_s; // R18
        end
    end

    // Sticky overload flag; a live event beats the clear
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            overload_flag_reg <= cds_pkg::CDS_FLAGS_RST;
        end else if (diag_clr_point) begin
            // Set wins, so a lasting fault reappears at once
            overload_flag_reg <= overload_s | dyn_sd_s; // R7 R16
        end else begin
            overload_flag_reg <= overload_flag_reg | overload_s | dyn_sd_s;
        end
    end

    // Dynamic shutdown feeds the same sticky flag
    // and is re-set each cycle while it persists

    // Thermal latch: set by the sensor, cleared only by command
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ot_latch_reg <= cds_pkg::CDS_FLAGS_RST;
        end else if (ctl_cmd) begin
            // Sensor still hot keeps its latch set
            ot_latch_reg <= over_temp_s; // R15
        end else begin
            // Held regardless of channel on command
            ot_latch_reg <= ot_latch_reg | over_temp_s; // R8
        end
    end

    // Re-arm sequence after a clear command
    always_comb begin
        ot_state_next = ot_state_reg;
        case (ot_state_reg)
            cds_pkg::CDS_OT_ARMED: begin
                if (ctl_cmd) begin
                    ot_state_next = cds_pkg::CDS_OT_WAIT_FRAME;
                end
            end
            cds_pkg::CDS_OT_WAIT_FRAME: begin
                // Copy clears at the next frame's clear point
                if (clr_point) begin
                    ot_state_next = cds_pkg::CDS_OT_WAIT_ARM; // R5
                end
            end
            cds_pkg::CDS_OT_WAIT_ARM: begin
                // Capture resumes after the third edge
                if (arm_point) begin
                    ot_state_next = cds_pkg::CDS_OT_ARMED; // R5
                end
            end
            default: begin
                ot_state_next = cds_pkg::CDS_OT_ARMED;
            end
        endcase
    end

    // Sequence state register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ot_state_reg <= cds_pkg::CDS_OT_ARMED;
        end else begin
            ot_state_reg <= ot_state_next;
        end
    end

    // Thermal copy in the fault flag; outlives the latch by one word
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ot_copy_reg <= cds_pkg::CDS_FLAGS_RST;
        end else if (ot_state_reg == cds_pkg::CDS_OT_WAIT_FRAME &&
                clr_point) begin
            ot_copy_reg <= cds_pkg::CDS_FLAGS_RST; // R5
        end else if (ot_state_reg == cds_pkg::CDS_OT_ARMED) begin
            // Not cleared by the command itself, so the next word
            // still reports the earlier thermal fault
            ot_copy_reg <= ot_copy_reg | ot_latch_reg; // R6
        end
    end

    // Reported fault flag is the OR of both parts
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            channel_fault_flag <= cds_pkg::CDS_FLAGS_RST;
        end else begin
            // Open load and short to supply have no source here: read 0
            channel_fault_flag <= overload_flag_reg | ot_copy_reg; // R1 R9
        end
    end

    // Gate enable: commanded on, not thermally latched and no dynamic shutdown
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            gate_enable <= cds_pkg::CDS_FLAGS_RST;
        end else begin
            gate_enable <= channel_on_command & ~ot_latch_reg &
                ~ot_latch_next_hot(over_temp_s) & ~dyn_sd_s; // R4
        end
    end

    // The sensor itself also forces off in the cycle it trips
    function automatic logic [5:0] ot_latch_next_hot(input logic [5:0] hot);
        ot_latch_next_hot = hot;
    endfunction

    // Latch state exposed for the gate control and status
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            thermal_latch <= cds_pkg::CDS_FLAGS_RST;
        end else begin
            thermal_latch <= ot_latch_reg;
        end
    end

    // Sense mux: channel number follows the select field
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sense_route <= cds_pkg::CDS_SEL_RST;
        end else begin
            sense_route <= sense_channel_select; // R12
        end
    end

    // Sense drive: selected, on, and no overload or thermal fault
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sense_drive_en <= 1'b0;
        end else begin
            // Code 110 and unused codes give an empty mask
            sense_drive_en <= |(sel_mask(sense_channel_select) & // R17
                channel_on_command & ~overload_s & ~dyn_sd_s & // R10
                ~ot_latch_reg & ~over_temp_s); // R11
        end
    end

    // Bypass monitor: comparator of the selected channel only
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bypass_monitor_result <= 1'b0;
        end else if (sel_is_channel(sense_channel_select)) begin
            // Near ground reads 1, near supply reads 0
            bypass_monitor_result <=
                near_gnd_s[sense_channel_select]; // R13 R14
        end else begin
            // Disabled mux: no channel compared
            bypass_monitor_result <= 1'b0;
        end
    end

endmodule

/* File: cds_diag_props.sv */
// Concurrent checks on the diagnosis block ports
`timescale 1ns/1ps
module cds_diag_props (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic spi_cs_n,
    input wire logic hardware_config_command_wr,
    input wire logic clear_thermal_latch,
    input wire logic [2:0] sense_channel_select,
    input wire logic [5:0] channel_on_command,
    input wire logic [5:0] overload_in,
    input wire logic [5:0] dyn_temp_shutdown_in,
    input wire logic [5:0] over_temp_in,
    input wire logic [5:0] out_near_gnd_in,
    input wire logic [5:0] channel_fault_flag,
    input wire logic [5:0] diag_word_snapshot,
    input wire logic [5:0] gate_enable,
    input wire logic [5:0] thermal_latch,
    input wire logic sense_drive_en,
    input wire logic [2:0] sense_route,
    input wire logic bypass_monitor_result
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic cmd; // Clear command seen this cycle
    logic [5:0] bad; // Pin-level reasons a channel must not sense; the thermal latch is not included
    logic [5:0] ovl_hold; // Overload high for five samples
    logic [5:0] ovl_q [4];
    logic [3:0] cs_age; // Cycles since select was low
    assign cmd = hardware_config_command_wr & clear_thermal_latch;
    assign bad = overload_in | over_temp_in | dyn_temp_shutdown_in
        | ~channel_on_command;
    assign ovl_hold = overload_in & ovl_q[0] & ovl_q[1] & ovl_q[2] & ovl_q[3];
    // Overload history, cleared so stale pins never count
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ovl_q <= '{default: 6'h00};
        end else begin
            ovl_q <= '{overload_in, ovl_q[0], ovl_q[1], ovl_q[2]};
        end
    end
    // Saturating age; frame events land a few cycles late
    always_ff @(posedge sys_clk) begin
        if (rst || !spi_cs_n) begin
            cs_age <= 4'h0;
        end else if (cs_age != 4'hf) begin
            cs_age <= cs_age + 4'h1;
        end
    end
    sequence s_cool;
        (over_temp_in == 6'h00)[*4];
    endsequence
    sequence s_pins_steady;
        ($stable(sense_channel_select) && $stable(out_near_gnd_in)
            && $stable(bad))[*6];
    endsequence
    property p_gate_off_latched;
        (thermal_latch & $past(thermal_latch) & gate_enable) == 6'h00;
    endproperty
    property p_latch_fall_cause;
        |($past(thermal_latch) & ~thermal_latch) |->
            $past(cmd) || $past(cmd, 2);
    endproperty
    property p_ctl_clears;
        s_cool ##0 cmd |-> ##[1:2] (thermal_latch == 6'h00);
    endproperty
    property p_fault_fall_in_frame;
        |($past(channel_fault_flag) & ~channel_fault_flag) |-> cs_age <= 4'h8;
    endproperty
    property p_snapshot_in_frame;
        $changed(diag_word_snapshot) |-> cs_age <= 4'h8;
    endproperty
    property p_overload_persists;
        (ovl_hold & ~channel_fault_flag) == 6'h00;
    endproperty
    property p_bypass_follows;
        s_pins_steady |-> bypass_monitor_result == ((sense_channel_select
            < 3'h6) && out_near_gnd_in[sense_channel_select]);
    endproperty
    property p_sense_off_fault;
        s_pins_steady |-> !sense_drive_en || (sense_channel_select < 3'h6
            && !bad[sense_channel_select]);
    endproperty
    property p_sense_off_disabled;
        sense_route >= 3'h6 |-> !sense_drive_en;
    endproperty
    a_gate_off_latched: assert property (p_gate_off_latched)
        else $error("gate on while latched");
    a_latch_fall_cause: assert property (p_latch_fall_cause)
        else $error("latch fell without clear command");
    a_ctl_clears: assert property (p_ctl_clears)
        else $error("clear command left a latch set");
    a_fault_fall_in_frame: assert property (p_fault_fall_in_frame)
        else $error("fault flag fell outside a frame");
    a_snapshot_in_frame: assert property (p_snapshot_in_frame)
        else $error("snapshot moved outside a frame");
    a_overload_persists: assert property (p_overload_persists)
        else $error("steady overload not flagged");
    a_bypass_follows: assert property (p_bypass_follows)
        else $error("bypass result wrong");
    a_sense_off_fault: assert property (p_sense_off_fault)
        else $error("sense driven on faulty or off channel");
    a_sense_off_disabled: assert property (p_sense_off_disabled)
        else $error("sense driven while disabled");
endmodule

/* File: cds_host_model.sv */
// Host side of the serial link, framing with its own clock
`timescale 1ns/1ps
module cds_host_model (
    output logic spi_sclk,
    output logic spi_cs_n,
    output logic spi_diag_frame
);
    // Link idles with clock low and select high
    initial begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_diag_frame = 1'b0;
    end
    // One frame of rising edges, 15 ns period, phase offset
    task automatic frame(input logic diag, input int edges);
        #3;
        spi_diag_frame = diag;
        spi_cs_n = 1'b0;
        #7.5;
        repeat (edges) begin
            spi_sclk = 1'b1;
            #7.5;
            spi_sclk = 1'b0;
            #7.5;
        end
        spi_cs_n = 1'b1;
        // Released level flips so a stale value never looks valid
        spi_diag_frame = ~diag;
        #20;
    endtask
endmodule

/* File: cds_diag_tb_top.sv */
// Self-checking bench for the channel diagnosis block
`timescale 1ns/1ps
module cds_diag_tb_top;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic spi_sclk, spi_cs_n, spi_diag_frame, sense_drive_en;
    logic hardware_config_command_wr = 1'b0;
    logic clear_thermal_latch = 1'b0;
    logic bypass_monitor_result;
    logic [2:0] sense_channel_select = 3'h6;
    logic [2:0] sense_route;
    logic [5:0] channel_on_command = 6'h3f;
    logic [5:0] overload_in = 6'h00;
    logic [5:0] dyn_temp_shutdown_in = 6'h00;
    logic [5:0] over_temp_in = 6'h00;
    logic [5:0] out_near_gnd_in = 6'h00;
    logic [5:0] channel_fault_flag, diag_word_snapshot;
    logic [5:0] gate_enable, thermal_latch;
    int num_errors = 0;
    int checked = 0;
    cds_diag u_cds_diag (.*);
    cds_host_model u_cds_host_model (.*);
    always #5 sys_clk = ~sys_clk;
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(input string what, input logic [5:0] exp,
        input logic [5:0] got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One command write pulse carrying bit 0
    task automatic command(input logic bit0);
        @(posedge sys_clk);
        hardware_config_command_wr <= 1'b1;
        clear_thermal_latch <= bit0;
        @(posedge sys_clk);
        hardware_config_command_wr <= 1'b0;
        clear_thermal_latch <= 1'b0;
        cyc(4);
    endtask
    task automatic frame(input logic diag);
        u_cds_host_model.frame(diag, 8);
        cyc(8);
    endtask
    // Monitor pins, then wait out the synchronisers
    task automatic pins(input logic [5:0] ovl, dyn, ot);
        @(posedge sys_clk);
        overload_in <= ovl;
        dyn_temp_shutdown_in <= dyn;
        over_temp_in <= ot;
        cyc(6);
    endtask
    // Every select code, then a fault and an off channel
    task automatic t_sense;
        @(posedge sys_clk);
        out_near_gnd_in <= 6'h2d;
        for (int s = 0; s < 8; s++) begin
            @(posedge sys_clk);
            sense_channel_select <= 3'(s);
            cyc(6);
            chk("route", 6'(s), 6'(sense_route));
            chk("drive", 6'(s < 6), 6'(sense_drive_en));
            chk("bypass", s < 6 ? (6'h2d >> s) & 6'h01 : 6'h00,
                6'(bypass_monitor_result));
        end
        @(posedge sys_clk);
        sense_channel_select <= 3'h0;
        pins(6'h01, 6'h00, 6'h00);
        chk("drive fault", 6'h00, 6'(sense_drive_en));
        pins(6'h00, 6'h00, 6'h00);
        // Selected channel commanded off must not drive the sense pin
        @(posedge sys_clk);
        channel_on_command <= 6'h3e;
        cyc(3);
        chk("drive off", 6'h00, 6'(sense_drive_en));
        @(posedge sys_clk);
        channel_on_command <= 6'h3f;
        cyc(3);
        frame(1'b1);
    endtask
    // Sticky overload kept by a plain frame, cleared by diagnosis
    task automatic t_sticky;
        pins(6'h04, 6'h00, 6'h00);
        pins(6'h00, 6'h00, 6'h00);
        chk("sticky", 6'h04, channel_fault_flag);
        frame(1'b0);
        chk("plain frame", 6'h04, channel_fault_flag);
        frame(1'b1);
        chk("word", 6'h04, diag_word_snapshot);
        chk("cleared", 6'h00, channel_fault_flag);
    endtask
    // Ongoing overload and dynamic shutdown survive each clear
    task automatic t_persist;
        pins(6'h10, 6'h08, 6'h00);
        frame(1'b1);
        frame(1'b1);
        chk("word", 6'h18, diag_word_snapshot);
        chk("again", 6'h18, channel_fault_flag);
        pins(6'h00, 6'h00, 6'h00);
        frame(1'b1);
        chk("gone", 6'h00, channel_fault_flag);
    endtask
    // Thermal latch, its clear and the second copy
    task automatic t_thermal;
        pins(6'h00, 6'h00, 6'h02);
        pins(6'h00, 6'h00, 6'h00);
        chk("latch", 6'h02, thermal_latch);
        chk("gate", 6'h3d, gate_enable);
        chk("flag", 6'h02, channel_fault_flag);
        @(posedge sys_clk);
        channel_on_command <= 6'h3d;
        cyc(3);
        command(1'b0);
        chk("kept", 6'h02, thermal_latch);
        command(1'b1);
        chk("clear", 6'h00, thermal_latch);
        chk("copy", 6'h02, channel_fault_flag);
        frame(1'b1);
        chk("first word", 6'h02, diag_word_snapshot);
        chk("copy gone", 6'h00, channel_fault_flag);
        frame(1'b1);
        pins(6'h00, 6'h00, 6'h01);
        chk("rearmed", 6'h01, channel_fault_flag);
    endtask
    task automatic tally_and_finish;
        if (num_errors == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        // Reset stands for two clock edges, then releases
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        cyc(1);
        chk("route rst", 6'h06, 6'(sense_route));
        chk("flags rst", 6'h00, channel_fault_flag);
        t_sense();
        t_sticky();
        t_persist();
        t_thermal();
        tally_and_finish();
    end
    // Watchdog well beyond the expected run
    initial begin
        #40000;
        num_errors++;
        tally_and_finish();
    end
endmodule
bind cds_diag cds_diag_props u_cds_diag_props (.*);
